// ==== design/i2c_masked_irq_status.sv ====
// masked interrupt status register of the i2c controller with apb slave
`timescale 1ns/1ps
`include "i2c_irq_regs.svh"

// Functional notes
// - bit 0 reads 1 while tx fifo empty and enabled.
// - bit 1 reads 1 when tx count at or below tx threshold.
// - bit 2 reads 1 while tx fifo full, subject to enable.
// - bit 3 sticks at 1 after a write to a full tx fifo.
// - bit 4 reads 1 while rx fifo empty.
// - bit 5 reads 1 when rx count at or above rx threshold.
// - bit 6 reads 1 while rx fifo full.
// - bit 16 reads 1 while a remote read request is pending.
// - bit 17 reads 1 when tx fifo empties during slave read.
// - bit 18 reads 1 while a remote write request is pending.
// - bit 19 reads 1 from master completion until acknowledged.
// - bit 20 reads 1 from slave completion until acknowledged.
// - bit 24 reads 1 after master arbitration loss.
// - bit 25 reads 1 after a detected bus error.
// - bit 28 reads 1 from master done without stop until acknowledged.
// - while no-stop done is pending, stretch clock and defer slave requests.
module i2c_masked_irq_status
(
    input  wire logic                       I_CLK_SYS,
    input  wire logic                       I_SRST,
    input  wire logic                       I_PSEL,
    input  wire logic                       I_PENABLE,
    input  wire logic                       I_PWRITE,
    input  wire logic [11:0]                I_PADDR,
    input  wire logic [31:0]                I_PWDATA,
    input  wire i2c_irq_pkg::engine_events_t I_EVENTS,
    output logic [31:0]                     O_PRDATA,
    output logic                            O_PREADY,
    output logic                            O_PSLVERR,
    output logic                            O_SCL_STRETCH,
    output logic                            O_SLAVE_REQ_HOLD
);
    // ==========================================================
    // bus request
    i2c_irq_pkg::apb_req_t req;
    logic                  wr_access;
    logic                  rd_access;
    logic                  mapped;

    assign req = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE,
                   paddr: I_PADDR, pwdata: I_PWDATA};

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr == `RAW_STATUS_OFFSET) || (addr == `MASKED_STATUS_OFFSET) ||
                    (addr == `IRQ_CLEAR_OFFSET) || (addr == `IRQ_MASK_OFFSET) ||
                    (addr == `TX_THRESHOLD_OFFSET) || (addr == `RX_THRESHOLD_OFFSET);
    endfunction

    // zero-wait slave: every access completes in its first access cycle
    assign O_PREADY  = 1'b1;
    assign mapped    = is_mapped(req.paddr);
    assign wr_access = req.psel && req.penable && req.pwrite;
    assign rd_access = req.psel && req.penable && !req.pwrite;
    assign O_PSLVERR = req.psel && req.penable && !mapped;

    // ==========================================================
    // software registers
    i2c_irq_pkg::word_t irq_mask_q;
    logic [3:0]         tx_level_threshold_q;
    logic [3:0]         rx_level_threshold_q;
    i2c_irq_pkg::word_t clear_pulse;

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
            irq_mask_q <= `MASK_RESET;
        else if (wr_access && req.paddr == `IRQ_MASK_OFFSET)
            irq_mask_q <= req.pwdata & `IMPLEMENTED_MASK;
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
        begin
            tx_level_threshold_q <= `THRESHOLD_RESET;
            rx_level_threshold_q <= `THRESHOLD_RESET;
        end
        else if (wr_access && req.paddr == `TX_THRESHOLD_OFFSET)
            tx_level_threshold_q <= req.pwdata[3:0];
        else if (wr_access && req.paddr == `RX_THRESHOLD_OFFSET)
            rx_level_threshold_q <= req.pwdata[3:0];
    end

    // clear register is write-one-to-clear; a zero bit leaves its flag alone
    assign clear_pulse = (wr_access && req.paddr == `IRQ_CLEAR_OFFSET) ?
                         (req.pwdata & `STICKY_MASK) : 32'h00000000;

    // ==========================================================
    // level conditions
    logic tx_empty;
    logic tx_near_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_near_full;
    logic rx_full;

    i2c_irq_level u_level
    (
        .i_tx_level           (I_EVENTS.tx_level),
        .i_rx_level           (I_EVENTS.rx_level),
        .i_tx_level_threshold (tx_level_threshold_q),
        .i_rx_level_threshold (rx_level_threshold_q),
        .o_tx_empty           (tx_empty),
        .o_tx_near_empty      (tx_near_empty),
        .o_tx_full            (tx_full),
        .o_rx_empty           (rx_empty),
        .o_rx_near_full       (rx_near_full),
        .o_rx_full            (rx_full)
    );

    // ==========================================================
    // sticky event flags
    logic tx_overrun;
    logic master_done;
    logic slave_done;
    logic arb_lost;
    logic bus_error;
    logic master_done_nostop;
    logic [5:0] sticky_set;
    logic [5:0] sticky_clr;
    logic [5:0] sticky_q;

    assign sticky_set = {I_EVENTS.master_done_nostop, I_EVENTS.bus_error,
                         I_EVENTS.arb_lost, I_EVENTS.slave_done,
                         I_EVENTS.master_done, I_EVENTS.tx_write && tx_full};
    assign sticky_clr = {clear_pulse[`BIT_MASTER_DONE_NOSTOP], clear_pulse[`BIT_BUS_ERROR],
                         clear_pulse[`BIT_ARB_LOST], clear_pulse[`BIT_SLAVE_DONE],
                         clear_pulse[`BIT_MASTER_DONE], clear_pulse[`BIT_TX_OVERRUN]};

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_flag
            i2c_irq_flag u_flag
            (
                .i_clk   (I_CLK_SYS),
                .i_srst  (I_SRST),
                .i_set   (sticky_set[g]),
                .i_clear (sticky_clr[g]),
                .o_flag  (sticky_q[g])
            );
        end
    endgenerate

    assign tx_overrun         = sticky_q[0];
    assign master_done        = sticky_q[1];
    assign slave_done         = sticky_q[2];
    assign arb_lost           = sticky_q[3];
    assign bus_error          = sticky_q[4];
    assign master_done_nostop = sticky_q[5];

    // ==========================================================
    // slave request deferral
    // requests arriving during an unacknowledged no-stop completion are held back
    logic slv_read_req;
    logic slv_write_req;

    assign O_SCL_STRETCH    = master_done_nostop;
    assign O_SLAVE_REQ_HOLD = master_done_nostop;
    assign slv_read_req     = I_EVENTS.slv_read_req && !master_done_nostop;
    assign slv_write_req    = I_EVENTS.slv_write_req && !master_done_nostop;

    // ==========================================================
    // raw and masked status
    i2c_irq_pkg::word_t raw_status;
    i2c_irq_pkg::word_t masked_status;

    always_comb
    begin
        raw_status                          = 32'h00000000;
        raw_status[`BIT_TX_EMPTY]           = tx_empty;
        raw_status[`BIT_TX_NEAR_EMPTY]      = tx_near_empty;
        raw_status[`BIT_TX_FULL]            = tx_full;
        raw_status[`BIT_TX_OVERRUN]         = tx_overrun;
        raw_status[`BIT_RX_EMPTY]           = rx_empty;
        raw_status[`BIT_RX_NEAR_FULL]       = rx_near_full;
        raw_status[`BIT_RX_FULL]            = rx_full;
        raw_status[`BIT_SLV_READ_REQ]       = slv_read_req;
        raw_status[`BIT_SLV_READ_UNDER]     = tx_empty && I_EVENTS.slv_read_active;
        raw_status[`BIT_SLV_WRITE_REQ]      = slv_write_req;
        raw_status[`BIT_MASTER_DONE]        = master_done;
        raw_status[`BIT_SLAVE_DONE]         = slave_done;
        raw_status[`BIT_ARB_LOST]           = arb_lost;
        raw_status[`BIT_BUS_ERROR]          = bus_error;
        raw_status[`BIT_MASTER_DONE_NOSTOP] = master_done_nostop;
    end

    assign masked_status = raw_status & irq_mask_q & `IMPLEMENTED_MASK;

    // ==========================================================
    // read data
    // status registers ignore writes since no write path targets them
    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_SRST)
            O_PRDATA <= 32'h00000000;
        else if (req.psel && !req.penable && !req.pwrite)
        begin
            unique case (req.paddr)
                `RAW_STATUS_OFFSET:    O_PRDATA <= raw_status;
                `MASKED_STATUS_OFFSET: O_PRDATA <= masked_status;
                `IRQ_MASK_OFFSET:      O_PRDATA <= irq_mask_q;
                `TX_THRESHOLD_OFFSET:  O_PRDATA <= {28'h0000000, tx_level_threshold_q};
                `RX_THRESHOLD_OFFSET:  O_PRDATA <= {28'h0000000, rx_level_threshold_q};
                default:               O_PRDATA <= 32'h00000000;
            endcase
        end
    end
endmodule

// ==== design/i2c_irq_regs.svh ====
// register offsets, field positions and reset values of the interrupt status block
`ifndef I2C_IRQ_REGS_SVH
`define I2C_IRQ_REGS_SVH

`define RAW_STATUS_OFFSET      12'h030
`define MASKED_STATUS_OFFSET   12'h034
`define IRQ_CLEAR_OFFSET       12'h038
`define IRQ_MASK_OFFSET        12'h03c
`define TX_THRESHOLD_OFFSET    12'h040
`define RX_THRESHOLD_OFFSET    12'h044

`define BIT_TX_EMPTY           0
`define BIT_TX_NEAR_EMPTY      1
`define BIT_TX_FULL            2
`define BIT_TX_OVERRUN         3
`define BIT_RX_EMPTY           4
`define BIT_RX_NEAR_FULL       5
`define BIT_RX_FULL            6
`define BIT_SLV_READ_REQ       16
`define BIT_SLV_READ_UNDER     17
`define BIT_SLV_WRITE_REQ      18
`define BIT_MASTER_DONE        19
`define BIT_SLAVE_DONE         20
`define BIT_ARB_LOST           24
`define BIT_BUS_ERROR          25
`define BIT_MASTER_DONE_NOSTOP 28

`define IMPLEMENTED_MASK       32'h131f007f
`define STICKY_MASK            32'h131f0008
`define MASK_RESET             32'h00000000
`define THRESHOLD_RESET        4'h0
`define FIFO_DEPTH             5'h10

`endif

// ==== design/i2c_irq_pkg.sv ====
// types shared by the interrupt status block
package i2c_irq_pkg;

    typedef logic [31:0] word_t;
    typedef logic [4:0]  level_t;

    typedef struct packed {
        level_t tx_level;
        level_t rx_level;
        logic   tx_write;
        logic   slv_read_req;
        logic   slv_read_active;
        logic   slv_write_req;
        logic   master_done;
        logic   slave_done;
        logic   arb_lost;
        logic   bus_error;
        logic   master_done_nostop;
    } engine_events_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        word_t       pwdata;
    } apb_req_t;

endpackage

// ==== design/i2c_irq_flag.sv ====
// one sticky flag: hardware set wins over software clear
`timescale 1ns/1ps
module i2c_irq_flag
(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            o_flag <= 1'b0;
        else if (i_set)
            o_flag <= 1'b1;
        else if (i_clear)
            o_flag <= 1'b0;
    end
endmodule

// ==== design/i2c_irq_level.sv ====
// fifo level conditions derived from entry counts and thresholds
`timescale 1ns/1ps
`include "i2c_irq_regs.svh"
module i2c_irq_level
(
    input  wire logic [4:0] i_tx_level,
    input  wire logic [4:0] i_rx_level,
    input  wire logic [3:0] i_tx_level_threshold,
    input  wire logic [3:0] i_rx_level_threshold,
    output logic            o_tx_empty,
    output logic            o_tx_near_empty,
    output logic            o_tx_full,
    output logic            o_rx_empty,
    output logic            o_rx_near_full,
    output logic            o_rx_full
);
    assign o_tx_empty      = (i_tx_level == 5'h00);
    assign o_tx_near_empty = (i_tx_level <= {1'b0, i_tx_level_threshold});
    assign o_tx_full       = (i_tx_level >= `FIFO_DEPTH);
    assign o_rx_empty      = (i_rx_level == 5'h00);
    assign o_rx_near_full  = (i_rx_level >= {1'b0, i_rx_level_threshold});
    assign o_rx_full       = (i_rx_level >= `FIFO_DEPTH);
endmodule

// ==== dv/i2c_irq_engine_model.sv ====
// behavioural model of the bus engine feeding the status block
`timescale 1ns/1ps
module i2c_irq_engine_model
(
    input  wire logic                   i_clk,
    output i2c_irq_pkg::engine_events_t o_ev
);
    // ==========================================
    // event drive
    initial o_ev = '0;
    task automatic levels(input logic [4:0] tx, input logic [4:0] rx, input logic [2:0] s);
        @(posedge i_clk);
        o_ev.tx_level <= tx;
        o_ev.rx_level <= rx;
        {o_ev.slv_read_req, o_ev.slv_read_active, o_ev.slv_write_req} <= s;
    endtask
    // set events last exactly one cycle, as the engine issues them
    task automatic pulse(input logic [5:0] m);
        @(posedge i_clk);
        {o_ev.master_done_nostop, o_ev.bus_error, o_ev.arb_lost, o_ev.slave_done,
            o_ev.master_done, o_ev.tx_write} <= m;
        @(posedge i_clk);
        {o_ev.master_done_nostop, o_ev.bus_error, o_ev.arb_lost, o_ev.slave_done,
            o_ev.master_done, o_ev.tx_write} <= 6'h00;
    endtask
endmodule

// ==== dv/i2c_masked_irq_status_assertions.sv ====
// port checker for the masked interrupt status block
`timescale 1ns/1ps
`include "i2c_irq_regs.svh"
module i2c_irq_status_checker
(
    input wire logic                        I_CLK_SYS,
    input wire logic                        I_SRST,
    input wire logic                        I_PSEL,
    input wire logic                        I_PENABLE,
    input wire logic                        I_PWRITE,
    input wire logic [11:0]                 I_PADDR,
    input wire logic [31:0]                 I_PWDATA,
    input wire i2c_irq_pkg::engine_events_t I_EVENTS,
    input wire logic [31:0]                 O_PRDATA,
    input wire logic                        O_PREADY,
    input wire logic                        O_PSLVERR,
    input wire logic                        O_SCL_STRETCH,
    input wire logic                        O_SLAVE_REQ_HOLD
);
    // ==========================================
    // helpers
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SRST);
    logic mapped;
    logic acc;
    assign acc = I_PSEL && I_PENABLE;
    assign mapped = I_PADDR inside {`RAW_STATUS_OFFSET, `MASKED_STATUS_OFFSET,
        `IRQ_CLEAR_OFFSET, `IRQ_MASK_OFFSET, `TX_THRESHOLD_OFFSET, `RX_THRESHOLD_OFFSET};
    sequence s_rd(a);
        I_PSEL && !I_PENABLE && !I_PWRITE && I_PADDR == a;
    endsequence
    sequence s_clr;
        acc && I_PWRITE && I_PADDR == `IRQ_CLEAR_OFFSET && I_PWDATA[28];
    endsequence
    // ==========================================
    // properties
    a_ready_high: assert property (acc |-> O_PREADY) else $error("pready low");
    a_err_unmapped: assert property (acc && !mapped |-> O_PSLVERR) else $error("no slverr");
    a_err_mapped: assert property (acc && mapped |-> !O_PSLVERR) else $error("bad slverr");
    a_unmapped_zero: assert property (s_rd(12'h080) |=> O_PRDATA == 32'h0) else $error("rd");
    a_clear_reads0: assert property (s_rd(`IRQ_CLEAR_OFFSET) |=> O_PRDATA == 32'h0)
        else $error("clear register read not zero");
    a_resv_zero: assert property (s_rd(`MASKED_STATUS_OFFSET) |=>
        (O_PRDATA & ~`IMPLEMENTED_MASK) == 32'h0) else $error("reserved bits set");
    a_stretch_set: assert property (I_EVENTS.master_done_nostop |=> O_SCL_STRETCH)
        else $error("stretch not raised");
    a_stretch_clear: assert property (s_clr and !I_EVENTS.master_done_nostop
        |=> !O_SCL_STRETCH) else $error("stretch not released");
    a_stretch_keep: assert property (O_SCL_STRETCH && !(acc && I_PWRITE && I_PWDATA[28]
        && I_PADDR == `IRQ_CLEAR_OFFSET) |=> O_SCL_STRETCH) else $error("stretch dropped");
    a_hold_match: assert property (O_SLAVE_REQ_HOLD == O_SCL_STRETCH)
        else $error("hold differs");
endmodule
bind i2c_masked_irq_status i2c_irq_status_checker chk (.*);

// ==== dv/tb_i2c_masked_irq_status.sv ====
// self-checking bench for the masked interrupt status block
`timescale 1ns/1ps
module tb_i2c_masked_irq_status;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    i2c_irq_pkg::word_t pwdata = 32'h0;
    i2c_irq_pkg::word_t prdata;
    i2c_irq_pkg::engine_events_t ev;
    logic pready, pslverr, stretch, hold;
    int failures = 0;
    int compares = 0;
    i2c_irq_pkg::word_t q;
    logic e;
    always #5 clk = ~clk;
    i2c_irq_engine_model em (.i_clk(clk), .o_ev(ev));
    i2c_masked_irq_status dut (.I_CLK_SYS(clk), .I_SRST(srst), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_EVENTS(ev), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_SCL_STRETCH(stretch), .O_SLAVE_REQ_HOLD(hold));
    // ==========================================
    // bus and compare tasks
    task automatic apb(input logic w, input logic [11:0] a, input i2c_irq_pkg::word_t d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input i2c_irq_pkg::word_t x, input i2c_irq_pkg::word_t g);
        compares++;
        if (g !== x)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, input i2c_irq_pkg::word_t x, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, x, q);
    endtask
    function automatic i2c_irq_pkg::word_t lvl(input int tx, input int rx, input int th);
        lvl = {25'h0, rx >= 16, rx >= th, rx == 0, 1'b0, tx >= 16, tx <= th, tx == 0};
    endfunction
    // ==========================================
    // scenarios
    task automatic t_reset();
        rd(12'h034, 32'h0, "masked at reset");
        rd(12'h03c, 32'h0, "mask at reset");
        rd(12'h040, 32'h0, "tx threshold at reset");
        $display("test reset done");
    endtask
    task automatic t_levels();
        int tv[4] = '{0, 4, 5, 16};
        int rv[4] = '{0, 3, 4, 16};
        apb(1'b1, 12'h03c, 32'hffffffff);
        apb(1'b1, 12'h040, 32'h4);
        apb(1'b1, 12'h044, 32'h4);
        for (int i = 0; i < 4; i++)
        begin
            em.levels(5'(tv[i]), 5'(rv[i]), 3'b000);
            rd(12'h034, lvl(tv[i], rv[i], 4), "level bits");
        end
        $display("test levels done");
    endtask
    task automatic t_sticky();
        int b[6] = '{3, 19, 20, 24, 25, 28};
        em.levels(5'h10, 5'h01, 3'b000);
        for (int k = 0; k < 6; k++)
        begin
            em.pulse(6'(1 << k));
            rd(12'h034, 32'h4 | (32'h1 << b[k]), "sticky set");
            apb(1'b1, 12'h038, ~(32'h1 << b[k]));
            rd(12'h034, 32'h4 | (32'h1 << b[k]), "clear zero kept");
            apb(1'b1, 12'h038, 32'h1 << b[k]);
            rd(12'h034, 32'h4, "sticky cleared");
        end
        em.levels(5'h05, 5'h01, 3'b000);
        em.pulse(6'h01);
        rd(12'h034, 32'h0, "write not full");
        $display("test sticky done");
    endtask
    task automatic t_slave();
        em.levels(5'h00, 5'h01, 3'b010);
        rd(12'h034, 32'h00020003, "read underflow");
        em.levels(5'h05, 5'h01, 3'b101);
        rd(12'h034, 32'h00050000, "slave requests");
        em.pulse(6'h20);
        rd(12'h034, 32'h10000000, "requests deferred");
        chk("stretch", 32'h1, {31'h0, stretch});
        chk("hold", 32'h1, {31'h0, hold});
        apb(1'b1, 12'h038, 32'h10000000);
        rd(12'h034, 32'h00050000, "requests back");
        chk("stretch off", 32'h0, {31'h0, stretch});
        $display("test slave done");
    endtask
    task automatic t_mask();
        apb(1'b1, 12'h03c, 32'h1);
        em.levels(5'h00, 5'h00, 3'b000);
        rd(12'h030, 32'h13, "raw status");
        apb(1'b1, 12'h034, 32'hffffffff);
        rd(12'h034, 32'h1, "masked and");
        rd(12'h080, 32'h0, "unmapped read");
        chk("slverr", 32'h1, {31'h0, e});
        $display("test mask done");
    endtask
    // ==========================================
    // run control
    task automatic conclude();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_levels();
        t_sticky();
        t_slave();
        t_mask();
        conclude();
    end
    // the whole sequence needs well under two thousand cycles
    initial
    begin
        #200000;
        failures++;
        conclude();
    end
endmodule
